// ==== isp_i2c_slave_port.sv ====
// Two-wire slave port: condition detection, address match, byte shifting,
// clock stretching and the software register port.
// Assumes SCL and SDA arrive asynchronously and the bench resolves the open-drain wires.
`timescale 1ns/10ps

module isp_i2c_slave_port (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // Register port
  input  wire isp_pkg::isp_bus_req_t busReq,
  output logic [7:0]                 busRdata,
  // Two-wire pins
  input  wire isp_pkg::isp_pin_in_t  pinIn,
  output isp_pkg::isp_pin_out_t      pinOut,
  // Interrupt request toward the processor
  output logic                       irqReq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  isp_pkg::isp_pin_in_t pinSync1;
  isp_pkg::isp_pin_in_t pinSync2;
  isp_pkg::isp_pin_in_t pinPrev;

  isp_pkg::isp_state_t  state;
  logic [3:0]           bitCnt;
  logic [7:0]           rxShift;

  logic                 ackAllow;
  logic                 moduleOn;
  logic                 flagIrqAllow;
  logic                 byteDone;
  logic                 xferDir;
  logic                 busOccupied;
  logic                 ownAddrHit;
  logic                 lastNinth;

  logic [6:0]           ownSlaveAddr;
  logic [7:0]           byteBuffer;
  logic [7:0]           pinSelHigh;
  logic [7:0]           irqEnableLow;

  logic                 portOn;
  logic                 startCond;
  logic                 stopCond;
  logic                 sclRise;
  logic                 sclFall;
  logic                 addrDone;
  logic                 addrMatch;
  logic                 rxDone;
  logic                 ackEnd;
  logic                 ctrlWrite;
  logic                 next_sdaOe;
  logic                 next_sclOe;
  logic [2:0]           txIdx;
  logic [7:0]           ctrlView;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and condition detection

  // Two stages before any logic looks at the pins; a third keeps the last level
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= '{scl: 1'b1, sda: 1'b1};
      pinSync2 <= '{scl: 1'b1, sda: 1'b1};
      pinPrev  <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      pinSync1 <= pinIn;
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end

  // Pins belong to the port only with the right pin function selected
  assign portOn = moduleOn && (pinSelHigh[7:4] == isp_pkg::ISP_PINSEL_PATTERN); // RULE_13

  // A change of SDA with SCL steady high can only be a condition
  assign startCond = portOn && pinPrev.scl && pinSync2.scl
                     && pinPrev.sda && !pinSync2.sda; // RULE_01
  assign stopCond  = portOn && pinPrev.scl && pinSync2.scl
                     && !pinPrev.sda && pinSync2.sda; // RULE_02
  assign sclRise   = portOn && !pinPrev.scl && pinSync2.scl; // RULE_05
  assign sclFall   = portOn && pinPrev.scl && !pinSync2.scl; // RULE_05

  ////////////////////////////////////////////////////////////////////////////
  // Byte events

  // A byte ends on the fall after bit eight
  assign addrDone  = sclFall && (state == isp_pkg::ISP_ST_ADDR)
                     && (bitCnt == isp_pkg::ISP_BITS_PER_BYTE);
  assign addrMatch = (rxShift[7:1] == ownSlaveAddr); // RULE_06 RULE_14
  assign rxDone    = sclFall && (state == isp_pkg::ISP_ST_RX)
                     && (bitCnt == isp_pkg::ISP_BITS_PER_BYTE);
  assign ackEnd    = sclFall && ((state == isp_pkg::ISP_ST_ADDR_ACK)
                     || (state == isp_pkg::ISP_ST_RX_ACK)
                     || (state == isp_pkg::ISP_ST_TX_ACK));

  // Only this write clears byte done
  assign ctrlWrite = busReq.wr && (busReq.addr == isp_pkg::ISP_OFF_CTRL);
  // Counts down: MSB leaves first
  assign txIdx     = isp_pkg::ISP_LAST_BIT_IDX - bitCnt[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Conditions outrank byte progress
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state   <= isp_pkg::ISP_ST_IDLE;
      bitCnt  <= 4'h0;
      rxShift <= isp_pkg::ISP_RST_BYTE;
    end else if (!portOn) begin
      state  <= isp_pkg::ISP_ST_IDLE;
      bitCnt <= 4'h0;
    end else if (startCond) begin
      // Repeated START needs no special path: it simply restarts the address phase
      state  <= isp_pkg::ISP_ST_ADDR; // RULE_01 RULE_03
      bitCnt <= 4'h0;
    end else if (stopCond) begin
      state  <= isp_pkg::ISP_ST_IDLE; // RULE_02
      bitCnt <= 4'h0;
    end else begin
      case (state)
        isp_pkg::ISP_ST_ADDR, isp_pkg::ISP_ST_RX: begin
          if (sclRise && (bitCnt != isp_pkg::ISP_BITS_PER_BYTE)) begin
            rxShift <= {rxShift[6:0], pinSync2.sda}; // RULE_08
            bitCnt  <= bitCnt + 4'h1;
          end else if (sclFall && (bitCnt == isp_pkg::ISP_BITS_PER_BYTE)) begin
            bitCnt <= 4'h0;
            if (state == isp_pkg::ISP_ST_RX) begin
              state <= isp_pkg::ISP_ST_RX_ACK; // RULE_10
            end else if (addrMatch) begin
              state <= isp_pkg::ISP_ST_ADDR_ACK; // RULE_07
            end else begin
              state <= isp_pkg::ISP_ST_IGNORE;
            end
          end
        end
        isp_pkg::ISP_ST_ADDR_ACK: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (xferDir) begin
              state <= isp_pkg::ISP_ST_TX; // RULE_09 RULE_18
            end else begin
              state <= isp_pkg::ISP_ST_RX; // RULE_09 RULE_19
            end
          end
        end
        isp_pkg::ISP_ST_RX_ACK: begin
          if (sclFall) begin
            state  <= isp_pkg::ISP_ST_RX; // RULE_08
            bitCnt <= 4'h0;
          end
        end
        isp_pkg::ISP_ST_TX: begin
          // Bit index advances on SCL falling so SDA only moves with SCL low
          if (sclFall) begin
            if (bitCnt[2:0] == isp_pkg::ISP_LAST_BIT_IDX) begin
              state  <= isp_pkg::ISP_ST_TX_ACK; // RULE_04
              bitCnt <= 4'h0;
            end else begin
              bitCnt <= bitCnt + 4'h1; // RULE_04
            end
          end
        end
        isp_pkg::ISP_ST_TX_ACK: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (lastNinth) begin
              state <= isp_pkg::ISP_ST_IGNORE; // RULE_11
            end else begin
              state <= isp_pkg::ISP_ST_TX; // RULE_11
            end
          end
        end
        default: begin
          // Wait here for the next START
          bitCnt <= 4'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits set by the bus

  // An off port forgets the bus
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busOccupied <= 1'b0;
    end else if (startCond) begin
      busOccupied <= 1'b1; // RULE_21
    end else if (stopCond || !portOn) begin
      busOccupied <= 1'b0; // RULE_21
    end
  end

  // Latched at the address byte's end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ownAddrHit <= 1'b0;
    end else if (startCond || stopCond || !portOn) begin
      ownAddrHit <= 1'b0; // RULE_22
    end else if (addrDone && addrMatch) begin
      ownAddrHit <= 1'b1; // RULE_22
    end
  end

  // Held until the next matching address
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xferDir <= 1'b0;
    end else if (addrDone && addrMatch) begin
      xferDir <= rxShift[0]; // RULE_18 RULE_19
    end
  end

  // The ninth bit is read back from the wire, so a driven acknowledge shows as 0
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lastNinth <= 1'b0;
    end else if (sclRise && ((state == isp_pkg::ISP_ST_ADDR_ACK)
                 || (state == isp_pkg::ISP_ST_RX_ACK)
                 || (state == isp_pkg::ISP_ST_TX_ACK))) begin
      lastNinth <= pinSync2.sda; // RULE_23
    end
  end

  // Hardware setting wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      byteDone <= 1'b0;
    end else if (ackEnd && flagIrqAllow) begin
      byteDone <= 1'b1; // RULE_16
    end else if (ctrlWrite && !busReq.wdata[isp_pkg::ISP_CTRL_BYTE_DONE]) begin
      byteDone <= 1'b0; // RULE_20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Only the enables are stored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ackAllow     <= 1'b0;
      moduleOn     <= 1'b0;
      flagIrqAllow <= 1'b0;
    end else if (ctrlWrite) begin
      ackAllow     <= busReq.wdata[isp_pkg::ISP_CTRL_ACK_ALLOW]; // RULE_15
      moduleOn     <= busReq.wdata[isp_pkg::ISP_CTRL_MODULE_ON]; // RULE_15
      flagIrqAllow <= busReq.wdata[isp_pkg::ISP_CTRL_FLAG_IRQ]; // RULE_15
    end
  end

  // Load before enabling the port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ownSlaveAddr <= isp_pkg::ISP_RST_BYTE[6:0];
    end else if (busReq.wr && (busReq.addr == isp_pkg::ISP_OFF_ADDR)) begin
      ownSlaveAddr <= busReq.wdata[6:0]; // RULE_14
    end
  end

  // A received byte overwrites a software write landing in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      byteBuffer <= isp_pkg::ISP_RST_BYTE;
    end else if (rxDone) begin
      byteBuffer <= rxShift; // RULE_17 RULE_19
    end else if (busReq.wr && (busReq.addr == isp_pkg::ISP_OFF_DATA)) begin
      byteBuffer <= busReq.wdata; // RULE_17
    end
  end

  // Only the upper nibble picks the pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinSelHigh <= isp_pkg::ISP_RST_BYTE;
    end else if (busReq.wr && (busReq.addr == isp_pkg::ISP_OFF_PINSEL)) begin
      pinSelHigh <= busReq.wdata;
    end
  end

  // Only bit 7 is used here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqEnableLow <= isp_pkg::ISP_RST_BYTE;
    end else if (busReq.wr && (busReq.addr == isp_pkg::ISP_OFF_IEN)) begin
      irqEnableLow <= busReq.wdata;
    end
  end

  always_comb begin
    ctrlView                               = isp_pkg::ISP_RST_BYTE;
    ctrlView[isp_pkg::ISP_CTRL_ACK_ALLOW]  = ackAllow;
    ctrlView[isp_pkg::ISP_CTRL_MODULE_ON]  = moduleOn;
    ctrlView[isp_pkg::ISP_CTRL_FLAG_IRQ]   = flagIrqAllow;
    ctrlView[isp_pkg::ISP_CTRL_BYTE_DONE]  = byteDone;
    ctrlView[isp_pkg::ISP_CTRL_DIR]        = xferDir; // RULE_18
    ctrlView[isp_pkg::ISP_CTRL_BUSY]       = busOccupied;
    ctrlView[isp_pkg::ISP_CTRL_HIT]        = ownAddrHit;
    ctrlView[isp_pkg::ISP_CTRL_LAST9]      = lastNinth;
  end

  // Read data stand for exactly one cycle; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busRdata <= isp_pkg::ISP_RST_BYTE;
    end else if (!busReq.rd) begin
      busRdata <= isp_pkg::ISP_RST_BYTE;
    end else if (busReq.addr == isp_pkg::ISP_OFF_CTRL) begin
      busRdata <= ctrlView;
    end else if (busReq.addr == isp_pkg::ISP_OFF_ADDR) begin
      busRdata <= {1'b0, ownSlaveAddr};
    end else if (busReq.addr == isp_pkg::ISP_OFF_DATA) begin
      busRdata <= byteBuffer; // RULE_17
    end else if (busReq.addr == isp_pkg::ISP_OFF_PINSEL) begin
      busRdata <= pinSelHigh;
    end else if (busReq.addr == isp_pkg::ISP_OFF_IEN) begin
      busRdata <= irqEnableLow;
    end else begin
      busRdata <= isp_pkg::ISP_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_comb begin
    next_sdaOe = 1'b0;
    case (state)
      isp_pkg::ISP_ST_ADDR_ACK, isp_pkg::ISP_ST_RX_ACK: begin
        next_sdaOe = ackAllow; // RULE_07 RULE_10 RULE_25
      end
      isp_pkg::ISP_ST_TX: begin
        next_sdaOe = !byteBuffer[txIdx]; // RULE_08 RULE_12 RULE_17
      end
      default: begin
        next_sdaOe = 1'b0;
      end
    endcase
  end

  // No stretch once the master has ended a read or the address missed,
  // otherwise the master could never raise SCL for its STOP
  // Not in ADDR: a stale flag must not stretch a START
  assign next_sclOe = byteDone && ((state == isp_pkg::ISP_ST_RX)
                      || (state == isp_pkg::ISP_ST_TX)); // RULE_20

  // Levels stay low; enables move wires
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinOut <= '{sclOut: 1'b0, sclOe: 1'b0, sdaOut: 1'b0, sdaOe: 1'b0};
    end else begin
      pinOut.sclOut <= 1'b0; // RULE_12
      pinOut.sdaOut <= 1'b0; // RULE_12
      pinOut.sclOe  <= portOn && next_sclOe; // RULE_20
      pinOut.sdaOe  <= portOn && !startCond && !stopCond && next_sdaOe;
    end
  end

  // Registered: no decode glitch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= byteDone && flagIrqAllow && irqEnableLow[isp_pkg::ISP_IEN_SYS]; // RULE_24
    end
  end

endmodule

// ==== isp_pkg.sv ====
// Constants, types and register map of the two-wire slave port.
// Assumes one 200 MHz system clock and an 8-bit register port on it.
//
// Notes on behaviour
// RULE_01: SDA falling while SCL is high is a START and opens a message.
// RULE_02: SDA rising while SCL is high is a STOP and ends a message.
// RULE_03: A START before any STOP is a repeated START, handled like a fresh START.
// RULE_04: Transmitters change SDA only while SCL is low, except START and STOP.
// RULE_05: A bit is SDA sampled while SCL is high; the bit ends when SCL falls.
// RULE_06: First byte after a START is a 7-bit address plus direction bit.
// RULE_07: On an address match the slave pulls SDA low during the ninth clock.
// RULE_08: Data bytes follow the address byte, most significant bit first, one or more.
// RULE_09: Direction 0 means master writes to slave; 1 means slave sends to master.
// RULE_10: In a master write the slave acknowledges each received byte low.
// RULE_11: In a master read the master acknowledges until the last byte, then leaves high.
// RULE_12: Lines are open-drain: release for 1, pull low for 0.
// RULE_13: Pins serve the port only while pin select upper nibble holds 1010b.
// RULE_14: The address to match comes from the software-written own address register.
// RULE_15: Writing e0h to control/status sets acknowledge, module and flag enables.
// RULE_16: When enabled, the byte done flag rises after every byte moved.
// RULE_17: Buffer writes are sent on the next transmit byte; received bytes read there.
// RULE_18: The received direction bit sits in control bit 3; 1 selects transmit.
// RULE_19: Direction 0 selects receive and received bytes appear in the buffer.
// RULE_20: While the byte done flag is set SCL is held low; released on clear. Here SCL is held only in the RX and TX states.
// RULE_21: Bus busy is set by a START and cleared by a STOP.
// RULE_22: Address hit is set on a match; cleared by START, STOP or reset.
// RULE_23: Last ninth bit records the ninth bit: 0 acknowledge, 1 no acknowledge.
// RULE_24: Interrupt request needs flag interrupt enable bit 5 and system enable bit 7.
// RULE_25: Acknowledge is driven low only while the acknowledge enable bit is set.

package isp_pkg;

  localparam int unsigned ISP_DATA_W = 8;

  // Register byte offsets
  localparam logic [7:0] ISP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ISP_OFF_ADDR   = 8'h04;
  localparam logic [7:0] ISP_OFF_DATA   = 8'h08;
  localparam logic [7:0] ISP_OFF_PINSEL = 8'h0c;
  localparam logic [7:0] ISP_OFF_IEN    = 8'h10;

  // Control/status field positions
  localparam int unsigned ISP_CTRL_ACK_ALLOW = 7;
  localparam int unsigned ISP_CTRL_MODULE_ON = 6;
  localparam int unsigned ISP_CTRL_FLAG_IRQ  = 5;
  localparam int unsigned ISP_CTRL_BYTE_DONE = 4;
  localparam int unsigned ISP_CTRL_DIR       = 3;
  localparam int unsigned ISP_CTRL_BUSY      = 2;
  localparam int unsigned ISP_CTRL_HIT       = 1;
  localparam int unsigned ISP_CTRL_LAST9     = 0;
  localparam int unsigned ISP_IEN_SYS        = 7;

  // Reset values and patterns
  localparam logic [7:0] ISP_RST_BYTE       = 8'h00;
  localparam logic [3:0] ISP_PINSEL_PATTERN = 4'ha;
  localparam logic [3:0] ISP_BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0] ISP_LAST_BIT_IDX   = 3'h7;

  typedef enum logic [2:0] {
    ISP_ST_IDLE     = 3'b000,
    ISP_ST_ADDR     = 3'b001,
    ISP_ST_ADDR_ACK = 3'b011,
    ISP_ST_RX       = 3'b010,
    ISP_ST_RX_ACK   = 3'b110,
    ISP_ST_TX       = 3'b111,
    ISP_ST_TX_ACK   = 3'b101,
    ISP_ST_IGNORE   = 3'b100
  } isp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } isp_bus_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } isp_pin_in_t;

  typedef struct packed {
    logic sclOut;
    logic sclOe;
    logic sdaOut;
    logic sdaOe;
  } isp_pin_out_t;

endpackage

// ==== isp_i2c_slave_port_assertions.sv ====
// Concurrent checks on the two-wire slave port, seen from its ports only.
// Assumes one-cycle register strobes and wires resolved by the bench.
`timescale 1ns/10ps

module isp_i2c_slave_port_assertions (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  resetn,
  // Register port
  input wire isp_pkg::isp_bus_req_t busReq,
  input wire logic [7:0]            busRdata,
  // Pins and interrupt
  input wire isp_pkg::isp_pin_in_t  pinIn,
  input wire isp_pkg::isp_pin_out_t pinOut,
  input wire logic                  irqReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic       flagIrq, ienSys, moduleOn, busy, sclQ, sdaQ;
  logic [3:0] pinSel, quiet;
  wire ctrlWr    = busReq.wr && busReq.addr == isp_pkg::ISP_OFF_CTRL;
  wire ctrlRd    = busReq.rd && busReq.addr == isp_pkg::ISP_OFF_CTRL;
  wire portOn    = moduleOn && pinSel == isp_pkg::ISP_PINSEL_PATTERN;
  wire startSeen = sclQ && pinIn.scl && sdaQ && !pinIn.sda;
  wire stopSeen  = sclQ && pinIn.scl && !sdaQ && pinIn.sda;

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the enables software wrote
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flagIrq  <= 1'b0;
      moduleOn <= 1'b0;
      ienSys   <= 1'b0;
      pinSel   <= 4'h0;
    end else begin
      if (ctrlWr) begin
        flagIrq  <= busReq.wdata[isp_pkg::ISP_CTRL_FLAG_IRQ];
        moduleOn <= busReq.wdata[isp_pkg::ISP_CTRL_MODULE_ON];
      end
      if (busReq.wr && busReq.addr == isp_pkg::ISP_OFF_IEN) begin
        ienSys <= busReq.wdata[isp_pkg::ISP_IEN_SYS];
      end
      if (busReq.wr && busReq.addr == isp_pkg::ISP_OFF_PINSEL) begin
        pinSel <= busReq.wdata[7:4];
      end
    end
  end

  // Bus state from the wires; quiet lets the port's synchroniser catch up
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclQ  <= 1'b1;
      sdaQ  <= 1'b1;
      busy  <= 1'b0;
      quiet <= 4'h0;
    end else begin
      sclQ <= pinIn.scl;
      sdaQ <= pinIn.sda;
      if (startSeen || stopSeen) begin
        busy  <= startSeen;
        quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
        quiet <= quiet + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_never_high;
    pinOut.sclOut == 1'b0 && pinOut.sdaOut == 1'b0;
  endproperty
  property p_sda_moves_low;
    $changed(pinOut.sdaOe) |-> !pinIn.scl;
  endproperty
  property p_sda_stable_high;
    pinIn.scl && $past(pinIn.scl) |-> $stable(pinOut.sdaOe);
  endproperty
  property p_stretch_on_low;
    $rose(pinOut.sclOe) |-> !pinIn.scl;
  endproperty
  property p_stretch_release;
    ctrlWr && !busReq.wdata[isp_pkg::ISP_CTRL_BYTE_DONE] |-> ##[1:4] !pinOut.sclOe;
  endproperty
  property p_irq_gate;
    irqReq |-> (ienSys || $past(ienSys)) && (flagIrq || $past(flagIrq));
  endproperty
  property p_port_off_quiet;
    (!portOn)[*3] |-> !pinOut.sdaOe && !pinOut.sclOe;
  endproperty
  property p_busy_status;
    ctrlRd && portOn && quiet == 4'hf |=> busRdata[isp_pkg::ISP_CTRL_BUSY] == busy;
  endproperty

  a_never_high: assert property (p_never_high) else $error("pin driven high");
  a_sda_moves_low: assert property (p_sda_moves_low) else $error("SDA moved, SCL high");
  a_sda_stable_high: assert property (p_sda_stable_high) else $error("SDA unstable");
  a_stretch_on_low: assert property (p_stretch_on_low) else $error("stretch on high");
  a_stretch_release: assert property (p_stretch_release) else $error("SCL held");
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  a_port_off_quiet: assert property (p_port_off_quiet) else $error("drive while off");
  a_busy_status: assert property (p_busy_status) else $error("busy status wrong");

  c_stretch: cover property ($rose(pinOut.sclOe));
  c_irq: cover property ($rose(irqReq));
  c_busy_read: cover property (ctrlRd && busy && quiet == 4'hf);
endmodule

bind isp_i2c_slave_port isp_i2c_slave_port_assertions u_chk (
  .clk_sys  (clk_sys),
  .resetn   (resetn),
  .busReq   (busReq),
  .busRdata (busRdata),
  .pinIn    (pinIn),
  .pinOut   (pinOut),
  .irqReq   (irqReq)
);

// ==== isp_master_model.sv ====
// Two-wire bus master driven by bench tasks, 165 ns bit period.
// Assumes pull-ups on both wires; the bench resolves them.
`timescale 1ns/10ps

module isp_master_model (
  // Resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // High pulls the wire low
  output logic      sclLow,
  output logic      sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // Bounded, so a slave that never lets go cannot hang the run
  task automatic releaseScl();
    sclLow <= 1'b0;
    #5;
    for (int i = 0; i < 20000 && !scl; i++) #5;
  endtask

  task automatic startCond();
    sdaLow <= 1'b0;
    #40;
    releaseScl();
    #40;
    sdaLow <= 1'b1;
    #40;
    sclLow <= 1'b1;
    #40;
  endtask

  task automatic stopCond();
    sdaLow <= 1'b1;
    #40;
    releaseScl();
    #40;
    sdaLow <= 1'b0;
    #80;
  endtask

  task automatic bitIo(input logic b, output logic r);
    sdaLow <= ~b;
    #40;
    releaseScl();
    #40;
    r = sda;
    #40;
    sclLow <= 1'b1;
    #40;
  endtask

  task automatic xferByte(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
                          output logic ackIn);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(ackOut, ackIn);
  endtask
endmodule

// ==== tb.sv ====
// Bench for the two-wire slave port: register tasks, a bus master model and
// a monitor checking read data against queued notes.
// Assumes a 200 MHz clock and pull-ups on both wires.
`timescale 1ns/10ps

module tb;
  typedef struct {
    string      name;
    logic [7:0] exp;
    logic [7:0] mask;
  } isp_note_t;

  logic                  clk_sys = 1'b0;
  logic                  resetn  = 1'b0;
  isp_pkg::isp_bus_req_t busReq  = '0;
  logic [7:0]            busRdata, rx, d0, d1;
  isp_pkg::isp_pin_in_t  pinIn;
  isp_pkg::isp_pin_out_t pinOut;
  logic                  irqReq, mSclLow, mSdaLow, ack;
  logic                  rdSeen = 1'b0;
  logic [15:0]           rnd = 16'he1eb;
  logic [6:0]            own;
  int                    failures = 0;
  int                    samples_checked = 0;
  isp_note_t             notes[$];

  always #2.5 clk_sys = ~clk_sys;
  assign pinIn = {~(pinOut.sclOe === 1'b1 || mSclLow),
                  ~(pinOut.sdaOe === 1'b1 || mSdaLow)};

  isp_i2c_slave_port u_dut (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .busReq   (busReq),
    .busRdata (busRdata),
    .pinIn    (pinIn),
    .pinOut   (pinOut),
    .irqReq   (irqReq)
  );
  isp_master_model u_master (
    .scl    (pinIn.scl),
    .sda    (pinIn.sda),
    .sclLow (mSclLow),
    .sdaLow (mSdaLow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask

  task automatic regRd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                       input string n);
    @(posedge clk_sys);
    notes.push_back('{n, e, m});
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdSeen && notes.size() > 0) begin
      check(notes[0].name, busRdata & notes[0].mask, notes[0].exp);
      notes.delete(0);
    end
    rdSeen <= busReq.rd;
  end

  initial begin
    #200_000;
    failures++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    // Offset 14h is unmapped and must read zero
    for (int i = 0; i < 6; i++) regRd(8'(i * 4), 8'h00, 8'hff, "reset value");
    rnd = lfsrNext(rnd);
    own = rnd[6:0];
    regWr(isp_pkg::ISP_OFF_PINSEL, 8'ha0);
    regWr(isp_pkg::ISP_OFF_ADDR, {1'b0, own});
    regWr(isp_pkg::ISP_OFF_IEN, 8'h80);
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    regRd(isp_pkg::ISP_OFF_ADDR, {1'b0, own}, 8'h7f, "own address");
    regRd(isp_pkg::ISP_OFF_CTRL, 8'he0, 8'hff, "ctrl enabled");
    u_master.startCond();
    u_master.xferByte({own, 1'b0}, 1'b1, rx, ack);
    check("address ack", {7'h00, ack}, 8'h00);
    regRd(isp_pkg::ISP_OFF_CTRL, 8'hf6, 8'hff, "ctrl write");
    @(negedge clk_sys);
    check("stretch", {7'h00, pinOut.sclOe}, 8'h01);
    check("irq on", {7'h00, irqReq}, 8'h01);
    regWr(isp_pkg::ISP_OFF_IEN, 8'h00);
    repeat (3) @(negedge clk_sys);
    check("irq masked", {7'h00, irqReq}, 8'h00);
    regWr(isp_pkg::ISP_OFF_IEN, 8'h80);
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    rnd = lfsrNext(rnd);
    d0 = rnd[7:0];
    u_master.xferByte(d0, 1'b1, rx, ack);
    check("data ack", {7'h00, ack}, 8'h00);
    regRd(isp_pkg::ISP_OFF_DATA, d0, 8'hff, "received byte");
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    // Repeated START turns the message round into a read
    u_master.startCond();
    u_master.xferByte({own, 1'b1}, 1'b1, rx, ack);
    check("read address ack", {7'h00, ack}, 8'h00);
    regRd(isp_pkg::ISP_OFF_CTRL, 8'hfe, 8'hff, "ctrl read");
    rnd = lfsrNext(rnd);
    d1 = rnd[7:0];
    regWr(isp_pkg::ISP_OFF_DATA, d1);
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    u_master.xferByte(8'hff, 1'b0, rx, ack);
    check("sent byte", rx, d1);
    regWr(isp_pkg::ISP_OFF_DATA, ~d1);
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    u_master.xferByte(8'hff, 1'b1, rx, ack);
    check("next byte", rx, ~d1);
    u_master.stopCond();
    regRd(isp_pkg::ISP_OFF_CTRL, 8'h11, 8'h17, "ctrl stop");
    regWr(isp_pkg::ISP_OFF_CTRL, 8'he0);
    u_master.startCond();
    u_master.xferByte({own ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    check("foreign address", {7'h00, ack}, 8'h01);
    regRd(isp_pkg::ISP_OFF_CTRL, 8'he4, 8'hf6, "ctrl foreign");
    u_master.stopCond();
    // Acknowledge disabled first, then the pins taken from the port
    for (int k = 0; k < 2; k++) begin
      if (k == 1) regWr(isp_pkg::ISP_OFF_PINSEL, 8'h00);
      regWr(isp_pkg::ISP_OFF_CTRL, k == 0 ? 8'h40 : 8'he0);
      u_master.startCond();
      u_master.xferByte({own, 1'b0}, 1'b1, rx, ack);
      check("no ack", {7'h00, ack}, 8'h01);
      u_master.stopCond();
    end
    wrap_up();
  end
endmodule
